// file: hdl/ssmp_core.v
// Synchronous serial master port: transmit and receive FIFOs, baud
// divider, shift engine for SPI and control-word formats, pin routing.
// Assumes a free-running 3.6864 MHz reference on a pin and plain control
// ports driven by logic on sys_clk.
`timescale 1ns/1ps
`include "ssmp_defines.vh"

// Function
// - SPI back-to-back keeps frame low, no gap
// - SPI back-to-back stores word on following fall
// - Control format sends 8-bit word, captures reply after it
// - Idle or disabled: clock low, frame high; tx low when disabled
// - FIFO write starts frame, loads shifter, MSB out
// - Receive line undriven during control word
// - Reply bits latched on rising serial clock
// - Single frame: frame rises one period later
// - Tx holds bit zero; disable forces zero
// - Control back-to-back: frame low, direct follow
// - Serial clock is reference over 2 times N
// - Transmit FIFO 8 deep, receive 12 deep
// - Receive request at five filled entries
// - Transmit request while four or fewer filled
// - FIFO data is left-justified in 16 bits
// - Registers are 16-bit, full-word access
// - Separate transmit and receive DMA requests
// - Alternate select moves port to spare pins
// - Format field chooses SPI or control word
// - Reset leaves the port disabled
module ssmp_core
(
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        port_enable_bit,
  input  wire [1:0]  frame_format_field,
  input  wire [3:0]  data_size,
  input  wire [7:0]  clock_rate,
  input  wire        alt_pin_select,
  input  wire        ref_clk_pin,
  input  wire        tx_wr_en,
  input  wire [15:0] tx_wr_data,
  output reg         tx_not_full,
  input  wire        rx_rd_en,
  output reg  [15:0] rx_rd_data,
  output reg         rx_rd_valid,
  output reg         rx_not_empty,
  output reg         rx_overrun,
  output reg         tx_dma_req,
  output reg         rx_dma_req,
  output reg         port_busy,
  output reg         pri_sclk_o,
  output reg         pri_sclk_oe,
  output reg         pri_frame_o,
  output reg         pri_frame_oe,
  output reg         pri_tx_o,
  output reg         pri_tx_oe,
  input  wire        pri_rx_i,
  output reg         pri_rx_oe,
  output reg         gp_tx_o,
  output reg         gp_tx_oe,
  input  wire        gp_rx_i,
  output reg         gp_rx_oe,
  output reg         gp_sclk_o,
  output reg         gp_sclk_oe,
  output reg         gp_frame_o,
  output reg         gp_frame_oe,
  output reg         gp_pins_claimed
);

  // Enable and control sampling
  reg         en;             // Registered enable, cleared by reset
  reg         alt;            // Registered pin group select

  // Pin synchronisers
  reg  [2:0]  ref_sync;       // Reference clock stages
  reg         ref_lvl;        // Filtered reference level
  reg         ref_prev;       // Previous filtered level
  reg  [2:0]  rx_sync;        // Receive line stages
  reg         rx_lvl;         // Filtered receive level
  wire        rx_pin;         // Receive pin of the active group
  wire        ref_tick;       // Rising reference edge, one cycle

  // Baud divider
  reg  [7:0]  div_cnt;        // Reference edges in this half period
  reg         half_tick;      // One-cycle pulse per serial half period
  reg         div_armed;      // Partial first reference period skipped

  // Transmit FIFO
  reg  [15:0] tx_mem [0:7];   // Storage, indexed by pointer
  reg  [2:0]  tx_wp;          // Write index
  reg  [2:0]  tx_rp;          // Read index
  reg  [3:0]  tx_cnt;         // Filled entries
  wire        tx_push;        // Accepted write
  wire [3:0]  next_tx_cnt;    // Fill after this cycle

  // Receive FIFO
  reg  [15:0] rx_mem [0:11];  // Storage, indexed by pointer
  reg  [3:0]  rx_wp;          // Write index
  reg  [3:0]  rx_rp;          // Read index
  reg  [3:0]  rx_cnt;         // Filled entries
  wire        rx_pop;         // Accepted read
  wire        rx_store;       // Word complete this cycle; stored unless the FIFO is full
  wire [3:0]  next_rx_cnt;    // Fill after this cycle

  // Shift engine
  reg  [1:0]  state;          // Engine state
  reg         ctrl_fmt;       // Frame uses control-word format
  reg  [3:0]  dsz;            // Latched data size code
  reg  [15:0] tx_sh;          // Transmit shifter, MSB first
  reg  [15:0] rx_sh;          // Receive shifter, shifts in at bit 0
  reg  [4:0]  slot;           // Bit slot within the frame
  reg  [4:0]  last_slot;      // Final slot of the frame
  reg         sclk;           // Internal serial clock
  reg         frame_n;        // Internal frame line, active low
  reg         tx_bit;         // Internal transmit line
  wire        start_idle;     // First frame starts from idle
  wire        end_slot;       // Falling edge closing the last slot
  wire        chain;          // Next frame follows with no gap
  wire        load;           // Shifter takes the FIFO head
  wire        capture;        // This slot samples the receive line
  wire [4:0]  tx_bits;        // Bits driven from the shifter
  wire [3:0]  just;           // Left-justify shift amount
  wire [4:0]  next_slot;      // Slot after this one

  assign rx_pin   = alt ? gp_rx_i : pri_rx_i;
  assign ref_tick = ref_lvl & ~ref_prev;

  // Sample enable and pin select; reset leaves the port off
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      en  <= 1'b0;
      alt <= 1'b0;
    end
    else
    begin
      en  <= port_enable_bit;
      alt <= alt_pin_select;
    end
  end

  // Three-stage synchronisers; a change counts when stages two and three agree
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      ref_sync <= 3'h0;
      ref_lvl  <= 1'b0;
      ref_prev <= 1'b0;
      rx_sync  <= 3'h0;
      rx_lvl   <= 1'b0;
    end
    else
    begin
      ref_sync <= {ref_sync[1:0], ref_clk_pin};
      rx_sync  <= {rx_sync[1:0], rx_pin};
      ref_prev <= ref_lvl;
      // Accept reference level once settled
      if (ref_sync[1] == ref_sync[2])
        ref_lvl <= ref_sync[2];
      // Accept receive level once settled
      if (rx_sync[1] == rx_sync[2])
        rx_lvl <= rx_sync[2];
    end
  end

  // Half period is clock_rate+1 reference edges, so the bit rate is the
  // reference over 2*(clock_rate+1); restarted in idle for a clean first half
  always @(posedge sys_clk)
  begin
    if (srst || !en || state == `SSMP_ST_IDLE)
    begin
      div_cnt   <= 8'h00;
      div_armed <= 1'b0;
      half_tick <= 1'b0;
    end
    else if (ref_tick && !div_armed)
    begin
      // Frame starts at a random reference phase; drop that short period
      // so the first rise never samples before the slave's bit settles
      div_armed <= 1'b1;
      half_tick <= 1'b0;
    end
    else if (ref_tick)
    begin
      // Wrap at the programmed count
      if (div_cnt == clock_rate)
      begin
        div_cnt   <= 8'h00;
        half_tick <= 1'b1;
      end
      else
      begin
        div_cnt   <= div_cnt + 8'h01;
        half_tick <= 1'b0;
      end
    end
    else
      half_tick <= 1'b0;
  end

  // Engine decode
  assign tx_bits    = ctrl_fmt ? `SSMP_CTRL_BITS : {1'b0, dsz} + 5'd1;
  assign capture    = ~ctrl_fmt | (slot >= `SSMP_FIRST_REPLY);
  assign start_idle = (state == `SSMP_ST_IDLE) && en && (tx_cnt != 4'h0);
  assign end_slot   = (state == `SSMP_ST_RUN) && half_tick && sclk &&
                      (slot == last_slot);
  assign chain      = end_slot && (tx_cnt != 4'h0);
  assign load       = start_idle | chain;
  assign rx_store   = chain |
                      ((state == `SSMP_ST_TAIL) && half_tick);
  assign just       = 4'hf - dsz;
  assign next_slot  = slot + 5'd1;

  // Shift engine: drive on falling, sample on rising, clock low when idle
  always @(posedge sys_clk)
  begin
    if (srst || !en)
    begin
      state     <= `SSMP_ST_IDLE;
      sclk      <= `SSMP_SCLK_RST;
      frame_n   <= `SSMP_FRAME_RST;
      tx_bit    <= `SSMP_TX_RST;
      ctrl_fmt  <= 1'b0;
      dsz       <= 4'h0;
      tx_sh     <= 16'h0000;
      rx_sh     <= 16'h0000;
      slot      <= 5'h00;
      last_slot <= 5'h00;
    end
    else if (load)
    begin
      // Head entry loads the shifter as frame falls; MSB goes out now
      ctrl_fmt  <= (frame_format_field == `SSMP_FRF_CTRL);
      dsz       <= data_size;
      tx_sh     <= tx_mem[tx_rp];
      tx_bit    <= tx_mem[tx_rp][15];
      frame_n   <= 1'b0;
      sclk      <= 1'b0;
      slot      <= 5'h00;
      // Control format: 8 command slots, one wait slot, then the reply
      if (frame_format_field == `SSMP_FRF_CTRL)
        last_slot <= {1'b0, data_size} + `SSMP_CTRL_LAST_OFS;
      else
        last_slot <= {1'b0, data_size};
      state     <= `SSMP_ST_RUN;
    end
    else
    begin
      case (state)
        `SSMP_ST_IDLE:
        begin
          sclk <= 1'b0;
        end
        `SSMP_ST_RUN:
        begin
          if (half_tick && !sclk)
          begin
            // Rising edge: latch only reply or full-duplex slots
            sclk <= 1'b1;
            if (capture)
              rx_sh <= {rx_sh[14:0], rx_lvl};
          end
          else if (half_tick)
          begin
            // Falling edge: next bit out, or close the frame
            sclk <= 1'b0;
            if (slot == last_slot)
              state <= `SSMP_ST_TAIL;
            else
            begin
              slot <= next_slot;
              // Shifter empty after its bits: line keeps bit zero
              if (next_slot < tx_bits)
              begin
                tx_sh  <= {tx_sh[14:0], 1'b0};
                tx_bit <= tx_sh[14];
              end
            end
          end
        end
        `SSMP_ST_TAIL:
        begin
          // One full period after the last latch, frame rises
          if (half_tick)
          begin
            frame_n <= 1'b1;
            state   <= `SSMP_ST_IDLE;
          end
        end
        default:
        begin
          state <= `SSMP_ST_IDLE;
        end
      endcase
    end
  end

  // Transmit FIFO: 8 entries of 16 bits; disabling empties it
  assign tx_push     = tx_wr_en && (tx_cnt != `SSMP_TX_DEPTH);
  assign next_tx_cnt = tx_cnt + {3'h0, tx_push} - {3'h0, load};

  always @(posedge sys_clk)
  begin
    if (srst || !en)
    begin
      tx_wp  <= 3'h0;
      tx_rp  <= 3'h0;
      tx_cnt <= 4'h0;
    end
    else
    begin
      // Write at the tail when there is room
      if (tx_push)
      begin
        tx_mem[tx_wp] <= tx_wr_data;
        tx_wp         <= tx_wp + 3'h1;
      end
      // Engine takes the head
      if (load)
        tx_rp <= tx_rp + 3'h1;
      tx_cnt <= next_tx_cnt;
    end
  end

  // Receive FIFO: 12 entries; full FIFO drops the word and flags overrun
  assign rx_pop      = rx_rd_en && (rx_cnt != 4'h0);
  assign next_rx_cnt = rx_cnt +
                       {3'h0, rx_store && (rx_cnt != `SSMP_RX_DEPTH)} -
                       {3'h0, rx_pop};

  always @(posedge sys_clk)
  begin
    if (srst || !en)
    begin
      rx_wp       <= 4'h0;
      rx_rp       <= 4'h0;
      rx_cnt      <= 4'h0;
      rx_overrun  <= 1'b0;
      rx_rd_data  <= 16'h0000;
      rx_rd_valid <= 1'b0;
    end
    else
    begin
      // Store the received word left-justified
      if (rx_store && (rx_cnt != `SSMP_RX_DEPTH))
      begin
        rx_mem[rx_wp] <= rx_sh << just;
        rx_wp <= (rx_wp == `SSMP_RX_LAST_IDX) ? 4'h0 : rx_wp + 4'h1;
      end
      else if (rx_store)
        rx_overrun <= 1'b1;
      // Read returns the head one cycle later
      rx_rd_valid <= rx_pop;
      if (rx_pop)
      begin
        rx_rd_data <= rx_mem[rx_rp];
        rx_rp <= (rx_rp == `SSMP_RX_LAST_IDX) ? 4'h0 : rx_rp + 4'h1;
      end
      rx_cnt <= next_rx_cnt;
    end
  end

  // Status and the two separate service requests, from next fills
  always @(posedge sys_clk)
  begin
    if (srst || !en)
    begin
      tx_not_full  <= 1'b0;
      rx_not_empty <= 1'b0;
      tx_dma_req   <= 1'b0;
      rx_dma_req   <= 1'b0;
      port_busy    <= 1'b0;
    end
    else
    begin
      tx_not_full  <= (next_tx_cnt != `SSMP_TX_DEPTH);
      rx_not_empty <= (next_rx_cnt != 4'h0);
      tx_dma_req   <= (next_tx_cnt <= `SSMP_TX_REQ_FILL);
      rx_dma_req   <= (next_rx_cnt >= `SSMP_RX_REQ_FILL);
      port_busy    <= (state != `SSMP_ST_IDLE) || (next_tx_cnt != 4'h0);
    end
  end

  // Pin routing: the selected group carries the port, the other rests idle
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      pri_sclk_o      <= `SSMP_SCLK_RST;
      pri_frame_o     <= `SSMP_FRAME_RST;
      pri_tx_o        <= `SSMP_TX_RST;
      pri_sclk_oe     <= 1'b0;
      pri_frame_oe    <= 1'b0;
      pri_tx_oe       <= 1'b0;
      pri_rx_oe       <= 1'b0;
      gp_sclk_o       <= `SSMP_SCLK_RST;
      gp_frame_o      <= `SSMP_FRAME_RST;
      gp_tx_o         <= `SSMP_TX_RST;
      gp_sclk_oe      <= 1'b0;
      gp_frame_oe     <= 1'b0;
      gp_tx_oe        <= 1'b0;
      gp_rx_oe        <= 1'b0;
      gp_pins_claimed <= 1'b0;
    end
    else
    begin
      // Primary group
      pri_sclk_o      <= alt ? `SSMP_SCLK_RST  : sclk;
      pri_frame_o     <= alt ? `SSMP_FRAME_RST : frame_n;
      pri_tx_o        <= alt ? `SSMP_TX_RST    : tx_bit;
      pri_sclk_oe     <= en & ~alt;
      pri_frame_oe    <= en & ~alt;
      pri_tx_oe       <= en & ~alt;
      pri_rx_oe       <= 1'b0;
      // Spare general-purpose group
      gp_sclk_o       <= alt ? sclk    : `SSMP_SCLK_RST;
      gp_frame_o      <= alt ? frame_n : `SSMP_FRAME_RST;
      gp_tx_o         <= alt ? tx_bit  : `SSMP_TX_RST;
      gp_sclk_oe      <= en & alt;
      gp_frame_oe     <= en & alt;
      gp_tx_oe        <= en & alt;
      gp_rx_oe        <= 1'b0;
      gp_pins_claimed <= en & alt;
    end
  end

endmodule

// file: hdl/ssmp_defines.vh
// Constants for the synchronous serial master port: FIFO sizes,
// service-request levels, frame format codes, engine states, reset values.
// Assumes inclusion by ssmp_core.v only; definitions only, no logic.
`ifndef SSMP_DEFINES_VH
`define SSMP_DEFINES_VH

// FIFO geometry
`define SSMP_TX_DEPTH      4'd8
`define SSMP_RX_DEPTH      4'd12
`define SSMP_RX_LAST_IDX   4'd11

// Service request levels
`define SSMP_TX_REQ_FILL   4'd4
`define SSMP_RX_REQ_FILL   4'd5

// Frame format field codes
`define SSMP_FRF_SPI       2'h0
`define SSMP_FRF_PULSED    2'h1
`define SSMP_FRF_CTRL      2'h2

// Control word format slot layout
`define SSMP_CTRL_BITS     5'd8
`define SSMP_FIRST_REPLY   5'd9
`define SSMP_CTRL_LAST_OFS 5'd9

// Synchroniser depth for pin inputs
`define SSMP_SYNC_STAGES   3

// Engine states
`define SSMP_ST_IDLE       2'h0
`define SSMP_ST_RUN        2'h1
`define SSMP_ST_TAIL       2'h2

// Pin reset levels
`define SSMP_SCLK_RST      1'b0
`define SSMP_FRAME_RST     1'b1
`define SSMP_TX_RST        1'b0

`endif

// file: tb/ssmp_sva.sv
// Checker for the serial master port: idle levels, clock gating, routing
// and FIFO status relations.
// Assumes a bind onto ssmp_core; sees its ports only.
`timescale 1ns/1ps
module ssmp_sva
(
  input logic sys_clk,
  input logic srst,
  input logic port_enable_bit,
  input logic rx_rd_en,
  input logic tx_not_full,
  input logic rx_rd_valid,
  input logic rx_not_empty,
  input logic rx_overrun,
  input logic tx_dma_req,
  input logic rx_dma_req,
  input logic pri_sclk_o,
  input logic pri_sclk_oe,
  input logic pri_frame_o,
  input logic pri_frame_oe,
  input logic pri_tx_o,
  input logic pri_tx_oe,
  input logic gp_sclk_o,
  input logic gp_sclk_oe,
  input logic gp_frame_o,
  input logic gp_tx_o,
  input logic gp_pins_claimed
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_RST_IDLE:
    assert property ($fell(srst) |-> !pri_sclk_o && pri_frame_o && !pri_tx_o
      && !pri_tx_oe) else $error("pins not idle after reset");
  AST_OFF_IDLE:
    assert property (!port_enable_bit [*4] |-> !pri_sclk_o && pri_frame_o
      && !pri_tx_o && !gp_sclk_o && gp_frame_o && !gp_tx_o)
    else $error("pins not idle while disabled");
  AST_CLK_IN_FRAME:
    assert property (!(pri_sclk_o && pri_frame_o) && !(gp_sclk_o && gp_frame_o))
    else $error("serial clock high outside a frame");
  AST_ONE_ROUTE:
    assert property (!(pri_sclk_oe && gp_sclk_oe))
    else $error("both pin groups driven");
  AST_TX_FULL:
    assert property (!tx_not_full |-> !tx_dma_req)
    else $error("transmit request while full");
  AST_RX_REQ:
    assert property (rx_dma_req |-> rx_not_empty)
    else $error("receive request while empty");
  AST_RD_VALID:
    assert property (rx_rd_valid |-> $past(rx_rd_en))
    else $error("read valid without a request");
  AST_FRAME_END:
    assert property ((port_enable_bit [*4]) ##0 ($rose(pri_frame_o) &&
      pri_frame_oe) |-> !$past(pri_sclk_o) && !$past(pri_sclk_o, 8))
    else $error("frame ended too soon after last clock");
  AST_TX_HOLD:
    assert property ((port_enable_bit [*4]) ##0 (pri_frame_o && pri_tx_oe &&
      $past(pri_frame_o) && $past(pri_tx_oe)) |-> $stable(pri_tx_o))
    else $error("idle transmit line changed");
  AST_OVR_STICKY:
    assert property (rx_overrun && port_enable_bit |=> rx_overrun)
    else $error("overrun flag lost");
  cover property ($fell(pri_frame_o));
  cover property ($rose(rx_overrun));
  cover property ($rose(gp_pins_claimed));
endmodule

// file: tb/ssmp_slave.sv
// Off-chip slave model: latches on rising clock, replies on falling clock,
// toggles its data line whenever it is not driving.
// Assumes the master holds the clock low between frames.
`timescale 1ns/1ps
module ssmp_slave
(
  input  logic        sclk,
  input  logic        frame,
  input  logic        mosi,
  input  logic        ctrl_mode,
  input  logic [3:0]  size_code,
  input  logic [15:0] reply,
  output logic        miso,
  output logic [15:0] done_word
);
  logic [15:0] got = 16'h0;   // Bits latched this frame
  logic [4:0]  nrise = 5'h0;  // Rising edges this frame
  logic [4:0]  last;          // Rising edges in a whole frame
  assign last = ctrl_mode ? 5'd10 + size_code : 5'd1 + size_code;
  initial
    miso = 1'b0;
  // Frame start: MSB at once in SPI, released in control format
  always @(negedge frame)
  begin
    nrise = 5'h0;
    got = 16'h0;
    miso = ctrl_mode ? ~miso : reply[15];
  end
  // Line released at frame end
  always @(posedge frame)
    miso = ~miso;
  // Latch master bits; control format keeps the first eight only
  always @(posedge sclk)
    if (!frame)
    begin
      if (!ctrl_mode || nrise < 5'd8)
        got = {got[14:0], mosi};
      nrise = nrise + 5'd1;
    end
  // Reply after the decode wait, restart for a following frame
  always @(negedge sclk)
    if (!frame)
    begin
      if (nrise == last)
      begin
        done_word = got;
        got = 16'h0;
        nrise = 5'h0;
        miso = ctrl_mode ? ~miso : reply[15];
      end
      else if (!ctrl_mode)
        miso = reply[5'd15 - nrise];
      else if (nrise >= 5'd9)
        miso = reply[5'd24 - nrise];
      else
        miso = ~miso;
    end
endmodule

// file: tb/test_sync_serial_master_port.sv
// Testbench for the serial master port: frames against a slave model,
// FIFO levels, pin routing and disable.
// Assumes ssmp_core, ssmp_sva and ssmp_slave are compiled first.
`timescale 1ns/1ps
module test_sync_serial_master_port;
  logic [1:0]  frame_format_field;
  logic [3:0]  data_size;
  logic [7:0]  clock_rate;
  logic [15:0] tx_wr_data, rx_rd_data, reply, done_word, q[$];
  logic        sys_clk, srst, port_enable_bit, alt_pin_select, ref_clk_pin;
  logic        tx_wr_en, rx_rd_en, tx_not_full, rx_rd_valid, rx_not_empty;
  logic        rx_overrun, tx_dma_req, rx_dma_req, port_busy, gp_pins_claimed;
  logic        pri_sclk_o, pri_sclk_oe, pri_frame_o, pri_frame_oe, pri_tx_o;
  logic        pri_tx_oe, pri_rx_i, pri_rx_oe, gp_tx_o, gp_tx_oe, gp_rx_i;
  logic        gp_rx_oe, gp_sclk_o, gp_sclk_oe, gp_frame_o, gp_frame_oe;
  logic        sclk, frame, tx, miso, frame_q = 1'b1;
  int          miscompares = 0, n_compared = 0, frames = 0, cyc = 0;
  // Active pin group seen by the slave; the other group gets the inverted slave line
  assign sclk = alt_pin_select ? gp_sclk_o : pri_sclk_o;
  assign frame = alt_pin_select ? gp_frame_o : pri_frame_o;
  assign tx = alt_pin_select ? gp_tx_o : pri_tx_o;
  assign pri_rx_i = alt_pin_select ? ~miso : miso;
  assign gp_rx_i = alt_pin_select ? miso : ~miso;
  ssmp_core DUT (.*);
  ssmp_slave u_slave (.sclk(sclk), .frame(frame), .mosi(tx),
    .ctrl_mode(frame_format_field == 2'h2), .size_code(data_size),
    .reply(reply), .miso(miso), .done_word(done_word));
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    ref_clk_pin = 1'b0;
    forever #135.634 ref_clk_pin = ~ref_clk_pin;
  end
  // Count frame ends; cut a hang short
  always @(posedge sys_clk)
  begin
    frame_q <= frame;
    if (frame && !frame_q)
      frames <= frames + 1;
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      miscompares++;
      results();
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Write words on consecutive cycles, at most two per request outside
  // the fill test
  task automatic push(input logic [15:0] w[$]);
    tx_wr_en = 1'b1;
    foreach (w[i])
    begin
      tx_wr_data = w[i];
      tick();
    end
    tx_wr_en = 1'b0;
  endtask
  task automatic wait_idle;
    tick(2);
    for (int k = 0; k < 8000 && port_busy !== 1'b0; k++)
      tick();
    tick(3);
  endtask
  // Read n words, all expected equal
  task automatic pop(input int n, input logic [15:0] exp);
    rx_rd_en = 1'b1;
    repeat (n)
    begin
      tick();
      check("read valid", rx_rd_valid, 1'b1);
      check("read data", rx_rd_data, exp);
    end
    rx_rd_en = 1'b0;
    tick();
  endtask
  // One transfer run: words out, one frame, slave view, replies back
  task automatic run(input logic [15:0] w[$], input logic [15:0] got, rx);
    int f0;
    f0 = frames;
    push(w);
    wait_idle();
    check("frame count", frames - f0, 16'd1);
    check("slave word", done_word, got);
    check("tx idle bit", tx, got[0]);
    pop(w.size(), rx);
  endtask
  task automatic results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    srst = 1'b1;
    port_enable_bit = 1'b0;
    alt_pin_select = 1'b0;
    frame_format_field = 2'h0;
    data_size = 4'h3;
    clock_rate = 8'h00;
    tx_wr_en = 1'b0;
    tx_wr_data = 16'h0;
    rx_rd_en = 1'b0;
    reply = 16'h0;
    tick(12);
    check("reset sclk", pri_sclk_o, 1'b0);
    check("reset frame", pri_frame_o, 1'b1);
    check("reset tx", pri_tx_o, 1'b0);
    check("reset oe", pri_sclk_oe, 1'b0);
    srst = 1'b0;
    port_enable_bit = 1'b1;
    tick(3);
    check("tx request", tx_dma_req, 1'b1);
    check("rx request", rx_dma_req, 1'b0);
    check("rx oe", pri_rx_oe, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 13; i++)
    begin
      reply = {i[3:0], 12'h0};
      push('{{~i[3:0], 12'h0}});
      wait_idle();
      check("slave nibble", done_word, {12'h0, ~i[3:0]});
      check("rx request", rx_dma_req, i >= 4);
      check("overrun", rx_overrun, i == 12);
      check("not empty", rx_not_empty, 1'b1);
    end
    for (int i = 0; i < 12; i++)
      pop(1, {i[3:0], 12'h0});
    rx_rd_en = 1'b1;
    tick();
    check("empty read", rx_rd_valid, 1'b0);
    check("empty flag", rx_not_empty, 1'b0);
    rx_rd_en = 1'b0;
    $display("test fifo depth done");
    reply = 16'ha000;
    run('{16'h9000, 16'h6000}, 16'h0006, 16'ha000);
    frame_format_field = 2'h2;
    data_size = 4'hb;
    reply = 16'habc0;
    run('{16'hc300}, 16'h00c3, 16'habc0);
    run('{16'h5a00, 16'h3c00}, 16'h003c, 16'habc0);
    $display("test frames done");
    frame_format_field = 2'h0;
    data_size = 4'h7;
    alt_pin_select = 1'b1;
    tick(2);
    reply = 16'h5500;
    run('{16'ha500}, 16'h00a5, 16'h5500);
    check("pins claimed", gp_pins_claimed, 1'b1);
    check("primary oe", pri_sclk_oe, 1'b0);
    check("alt frame oe", gp_frame_oe, 1'b1);
    check("alt rx oe", gp_rx_oe, 1'b0);
    alt_pin_select = 1'b0;
    tick(2);
    $display("test alt pins done");
    clock_rate = 8'hff;
    data_size = 4'h3;
    repeat (9) q.push_back(16'hf000);
    push(q);
    tick(3);
    check("tx full", tx_not_full, 1'b0);
    check("tx request off", tx_dma_req, 1'b0);
    check("frame low", pri_frame_o, 1'b0);
    check("tx msb", pri_tx_o, 1'b1);
    port_enable_bit = 1'b0;
    tick(6);
    check("off frame", pri_frame_o, 1'b1);
    check("off tx", pri_tx_o, 1'b0);
    check("off sclk", pri_sclk_o, 1'b0);
    check("off busy", port_busy, 1'b0);
    $display("test disable done");
    results();
  end
endmodule
bind ssmp_core ssmp_sva u_sva (.*);
